// File: verilog/csd_top.sv
// top: window decode, display memory, register bank and strap capture
//
// Function
// [RQ1] Only low seventeen address bits select a location in the 128K window.
// [RQ2] Offsets 0 to 13FFFh reach display memory.
// [RQ3] Offsets 1FFE0h to 1FFFFh reach the register bank.
// [RQ4] Glue ignores A17 upward; controller aliases 512 times in the slot.
// [RQ5] Glue disregards register-space qualifier; controller fills slot one.
// [RQ6] System adds decoding to qualify chip select if aliases unwanted.
// [RQ7] Capture four strap pins at power-up and hold as configuration.
// [RQ8] Bus-variant strap high selects variant 2, low selects variant 1.
// [RQ9] Byte-order strap high means big-endian, low little-endian.
// [RQ10] Family straps 111 enable the generic host interface family.
// [RQ11] External latch holds upper address bits A25 to A13.
// [RQ12] Buffer supplies control pins and a 16M byte region in display mode.
// [RQ13] Buffer disables card-side signals while controller is accessed.
// [RQ14] Only one buffer chip may be in display mode.
// [RQ15] Host clears slot IO-enable bit for direct connection.
// [RQ16] With buffer, IO-enable bits have no effect; space is split three ways.
// [RQ17] Slot two buffered region at 0D000000h selects controller, 128 aliases.
// [RQ18] Variant 2 host drives high byte enable and read enable as stated.
// [RQ19] Hold wait asserted until read data ready or write data accepted.
// [RQ20] Variant 1 external logic makes separate byte read and write enables.
// [RQ21] Gap between memory and register bank is unused; reads undefined.
// [RQ22] Glue asserts chip select only for window match during a host cycle.
`default_nettype none
module csd_top
    import csd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire csd_pkg::csd_wb_req_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // strap pins
    input wire logic [3:0] power_up_config_straps_i,
    input wire logic bus_variant_strap_n_i,
    // configuration and wait
    output csd_pkg::csd_cfg_t cfg_o,
    output logic host_wait_n_o
);
    import csd_pkg::*;

    function automatic csd_region_t region_of(input logic [16:0] ofs);
        if (ofs <= MEM_LAST)
            region_of = CSD_MEM;
        else if (ofs >= REG_FIRST)
            region_of = CSD_REG;
        else
            region_of = CSD_UNUSED;
    endfunction

    // strap synchronisers
    logic [4:0] strap_s1_q, strap_s2_q;
    logic cfg_taken_q;
    csd_cfg_t cfg_q;
    logic [16:0] win_addr_q;
    logic [15:0] mem_q [0:MEM_WORDS-1];
    logic [15:0] regs_q [0:REG_COUNT-1];
    logic [31:0] dat_q;
    logic ack_q;
    logic wait_n_q;
    logic [15:0] rd_mem_q, rd_reg_q;

    always_ff @(posedge clk_i) begin
        strap_s1_q <= {bus_variant_strap_n_i, power_up_config_straps_i};
        strap_s2_q <= strap_s1_q;
    end

    // capture once, four cycles after reset release
    logic [1:0] settle_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_q <= 2'h0;
            cfg_taken_q <= 1'b0;
            cfg_q <= '0;
        end else begin
            if (settle_q != 2'h3)
                settle_q <= settle_q + 2'h1;
            else if (!cfg_taken_q) begin
                cfg_taken_q <= 1'b1; // RQ7
                cfg_q.straps <= strap_s2_q[3:0]; // RQ7
                cfg_q.variant_two <= strap_s2_q[4]; // RQ8
                cfg_q.big_endian <= strap_s2_q[3]; // RQ9
                cfg_q.generic_en <= (strap_s2_q[2:0] == FAMILY_GENERIC); // RQ10
            end
        end
    end

    // bus decode
    wire wb_sel_w = wb_i.cyc && wb_i.stb && !ack_q;
    wire wr_w = wb_sel_w && wb_i.we;
    wire [16:0] win_ofs_w = win_addr_q[ADDR_W-1:0]; // RQ1
    wire csd_region_t reg_w = region_of(win_ofs_w);
    wire is_data_w = (wb_i.adr == OFS_WIN_DATA);
    wire [15:0] mem_idx_w = win_ofs_w[16:1];
    wire [4:0] reg_idx_w = win_ofs_w[4:0];
    wire data_wr_w = wr_w && is_data_w && wb_i.sel[0] && wb_i.sel[1];
    wire mem_wr_w = data_wr_w && (reg_w == CSD_MEM); // RQ2
    wire reg_wr_w = data_wr_w && (reg_w == CSD_REG); // RQ3
    wire [15:0] win_rd_w = (reg_w == CSD_MEM) ? rd_mem_q :
                           (reg_w == CSD_REG) ? rd_reg_q : 16'hFFFF; // RQ21
    wire [31:0] rd_w = (wb_i.adr == OFS_CFG) ? {25'h0, cfg_q} :
                       (wb_i.adr == OFS_WIN_ADDR) ? {15'h0, win_addr_q} :
                       is_data_w ? {16'h0, win_rd_w} :
                       (wb_i.adr == OFS_STATUS) ? {28'h0, reg_w, cfg_taken_q, wait_n_q} : 32'h0;

    // memory and register arrays, read one cycle ahead of the answer
    always_ff @(posedge clk_i) begin
        rd_mem_q <= mem_q[(mem_idx_w < 16'(MEM_WORDS)) ? mem_idx_w : 16'h0];
        rd_reg_q <= regs_q[reg_idx_w];
        if (mem_wr_w)
            mem_q[mem_idx_w] <= wb_i.dat[15:0]; // RQ2
        if (reg_wr_w)
            regs_q[reg_idx_w] <= wb_i.dat[15:0]; // RQ3
    end

    // two-phase access: wait low during the fetch cycle, ack after
    logic busy_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            ack_q <= 1'b0;
            wait_n_q <= 1'b1;
            dat_q <= 32'h0;
            win_addr_q <= WIN_ADDR_RST;
        end else begin
            ack_q <= 1'b0;
            if (wb_sel_w && !busy_q) begin
                busy_q <= 1'b1;
                wait_n_q <= 1'b0; // RQ19
            end else if (busy_q) begin
                busy_q <= 1'b0;
                ack_q <= 1'b1;
                wait_n_q <= 1'b1; // RQ19
                dat_q <= rd_w;
                if (wb_i.we && wb_i.adr == OFS_WIN_ADDR && wb_i.sel[0])
                    win_addr_q <= wb_i.dat[16:0]; // RQ1
            end
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign cfg_o = cfg_q;
    assign host_wait_n_o = wait_n_q;

    a_wait_ack_pair: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        $fell(wait_n_q) |=> (wait_n_q && ack_q))
        else $error("ack did not follow wait by one cycle");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");
    a_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        cfg_taken_q && $past(cfg_taken_q) |-> $stable(cfg_q))
        else $error("captured configuration changed");
    a_cfg_generic: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
        $rose(cfg_taken_q) |-> cfg_q.generic_en == ($past(strap_s2_q[2:0]) == 3'h7))
        else $error("generic family bit wrong");
    a_cfg_variant: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
        $rose(cfg_taken_q) |-> cfg_q.variant_two == $past(strap_s2_q[4]))
        else $error("variant bit wrong");
    a_cfg_endian: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
        $rose(cfg_taken_q) |-> cfg_q.big_endian == $past(strap_s2_q[3]))
        else $error("endian bit wrong");
    a_mem_range: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
        mem_wr_w |-> win_ofs_w <= 17'h13FFF)
        else $error("memory write outside display range");
    a_reg_range: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        reg_wr_w |-> win_ofs_w >= 17'h1FFE0)
        else $error("register write outside bank range");
    a_gap_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RQ21
        (win_ofs_w > 17'h13FFF && win_ofs_w < 17'h1FFE0) |-> !mem_wr_w && !reg_wr_w)
        else $error("write landed in unused gap");

    // handshake timing: one busy cycle, then a single ack
    a_wait_busy_match: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        busy_q == !wait_n_q)
        else $error("wait output out of step with busy phase");
    a_busy_single: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        busy_q |=> !busy_q)
        else $error("busy phase longer than one cycle");
    a_ack_after_busy: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        ack_q |-> $past(busy_q))
        else $error("ack without a busy phase before it");
    a_req_answered: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        (wb_sel_w && !busy_q) |-> ##2 ack_q)
        else $error("request not answered two cycles after it was taken");
    a_idle_no_ack: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
        !busy_q |=> !ack_q)
        else $error("ack raised without a pending access");

    // window decode regions
    a_mem_decode: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
        (win_ofs_w <= MEM_LAST) |-> (reg_w == CSD_MEM))
        else $error("display memory offset not decoded as memory");
    a_reg_decode: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        (win_ofs_w >= REG_FIRST) |-> (reg_w == CSD_REG))
        else $error("register offset not decoded as register bank");
    a_gap_decode: assert property (@(posedge clk_i) disable iff (rst_i) // RQ21
        (win_ofs_w > MEM_LAST && win_ofs_w < REG_FIRST) |-> (reg_w == CSD_UNUSED))
        else $error("gap offset decoded as used");
    a_gap_read: assert property (@(posedge clk_i) disable iff (rst_i) // RQ21
        (ack_q && $past(is_data_w && !wb_i.we && reg_w == CSD_UNUSED)) |-> (dat_q == 32'h0000FFFF))
        else $error("gap read did not return the fill value");
    a_mem_index: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
        mem_wr_w |-> (mem_idx_w < 16'(MEM_WORDS)))
        else $error("memory write index beyond the array");
    a_addr_write: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
        (ack_q && $past(wb_i.we && wb_i.adr == OFS_WIN_ADDR && wb_i.sel[0])) |->
        (win_addr_q == $past(wb_i.dat[16:0])))
        else $error("window address not stored from low seventeen bits");

    // strap capture
    a_cfg_straps: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        $rose(cfg_taken_q) |-> (cfg_q.straps == $past(strap_s2_q[3:0])))
        else $error("captured strap levels wrong");
    a_cfg_once: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        cfg_taken_q |=> cfg_taken_q)
        else $error("capture flag dropped outside reset");
    a_cfg_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        !cfg_taken_q |-> ({cfg_q} == 7'h00))
        else $error("configuration set before capture");
endmodule
`default_nettype wire

// File: verilog/csd_pkg.sv
// package: constants and carrier types for the card slot host decode block
`default_nettype none
package csd_pkg;
    localparam int ADDR_W = 17;
    localparam logic [16:0] MEM_LAST = 17'h13FFF;
    localparam logic [16:0] REG_FIRST = 17'h1FFE0;
    localparam logic [16:0] REG_LAST = 17'h1FFFF;
    localparam int REG_COUNT = 32;
    localparam int MEM_WORDS = 40960;
    localparam logic [2:0] FAMILY_GENERIC = 3'h7;
    // wishbone register offsets (byte addresses)
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_WIN_ADDR = 8'h04;
    localparam logic [7:0] OFS_WIN_DATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [16:0] WIN_ADDR_RST = 17'h00000;
    localparam logic [15:0] CFG_RST = 16'h0000;
    // field positions (unused); config register has generic_en at bit 0, big_endian 1, variant_two 2, straps from 3
    localparam int CFG_VARIANT_BIT = 0;
    localparam int CFG_ENDIAN_BIT = 1;
    localparam int CFG_GENERIC_BIT = 2;
    localparam int CFG_STRAP_LSB = 4;
    typedef enum logic [1:0] {CSD_UNUSED, CSD_MEM, CSD_REG} csd_region_t;
    typedef struct packed {
        logic [3:0] straps;
        logic variant_two;
        logic big_endian;
        logic generic_en;
    } csd_cfg_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } csd_wb_req_t;
endpackage
`default_nettype wire

// File: dv/csd_host_glue.sv
// host-side glue model: slot address to controller window and chip select
`default_nettype none
module csd_host_glue (
    // host side
    input wire logic [25:0] slot_addr_i,
    input wire logic cycle_i,
    input wire logic slot_hit_i,
    // controller side
    output logic [16:0] win_ofs_o,
    output logic chip_sel_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // upper slot bits dropped, so the window repeats across the slot
    assign win_ofs_o = slot_addr_i[16:0];
    // register-space qualifier not part of the select; slot_hit_i is the extra alias decode
    assign chip_sel_n_o = !(cycle_i && slot_hit_i);
endmodule
`default_nettype wire

// File: dv/csd_top_test.sv
// self-checking bench: window decode, straps and wait through wishbone
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module csd_top_test
    import csd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, bv_n = 1'b0, wait_q = 1'b1, wb_ack_o, host_wait_n_o;
    logic [3:0] straps = 4'h0;
    logic [31:0] wb_dat_o, rd, seed = 32'h00003527;
    logic [25:0] slot = 26'h0000000;
    logic [16:0] ofs;
    logic [31:0] exp_q[$];
    csd_wb_req_t wb = '0;
    csd_cfg_t cfg_o;
    int mismatches = 0, n_compared = 0;
    csd_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .power_up_config_straps_i(straps), .bus_variant_strap_n_i(bv_n), .cfg_o(cfg_o),
        .host_wait_n_o(host_wait_n_o));
    csd_host_glue i_glue (.slot_addr_i(slot), .cycle_i(wb.cyc), .slot_hit_i(1'b1), .win_ofs_o(ofs),
        .chip_sel_n_o());
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one classic cycle; reads note their expected data first
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] ex);
        int n;
        n = 0;
        if (!we) exp_q.push_back(ex);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20) mismatches++;
        wb <= '0;
        @(posedge clk_i);
    endtask
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb.we === 1'b0) begin
            rd = exp_q.pop_front();
            `CHK("read data", rd, wb_dat_o)
        end
        if (wb_ack_o === 1'b1) `CHK("wait before ack", 1'b0, wait_q)
        wait_q <= host_wait_n_o;
    end
    initial begin
        #20000;
        mismatches++;
        finish_test();
    end
    initial begin
        logic [16:0] ofs_t[4] = '{17'h00000, 17'h13FFE, 17'h1FFE0, 17'h1FFFE};
        logic [16:0] gap[2] = '{17'h14000, 17'h1FFDE};
        logic [15:0] w[4];
        logic [6:0] c;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_i);
            seed = rnd();
            rst_i <= 1'b1;
            straps <= p ? {~straps[3], 3'h7} : {seed[3], 3'h5};
            bv_n <= p ? ~bv_n : seed[4];
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            repeat (5) @(posedge clk_i);
            c = {straps, bv_n, straps[3], straps[2:0] == 3'h7};
            `CHK("config pins", c, cfg_o)
            `CHK("idle wait", 1'b1, host_wait_n_o)
            bus(1'b0, OFS_CFG, 32'h0, {25'h0, c});
            for (int i = 0; i < 4; i++) begin
                seed = rnd();
                w[i] = seed[15:0];
                slot <= {seed[25:17], ofs_t[i]};
                @(posedge clk_i);
                `CHK("glue offset", ofs_t[i], ofs)
                bus(1'b1, OFS_WIN_ADDR, {seed[31:26], slot}, 32'h0);
                bus(1'b1, OFS_WIN_DATA, {seed[31:16], w[i]}, 32'h0);
            end
            for (int i = 0; i < 4; i++) begin
                bus(1'b1, OFS_WIN_ADDR, {15'h7FFF, ofs_t[i]}, 32'h0);
                bus(1'b0, OFS_WIN_ADDR, 32'h0, {15'h0, ofs_t[i]});
                bus(1'b0, OFS_WIN_DATA, 32'h0, {16'h0, w[i]});
            end
            for (int i = 0; i < 2; i++) begin
                bus(1'b1, OFS_WIN_ADDR, {15'h0, gap[i]}, 32'h0);
                bus(1'b1, OFS_WIN_DATA, 32'h00001234, 32'h0);
                bus(1'b0, OFS_WIN_DATA, 32'h0, 32'h0000FFFF);
            end
            bus(1'b1, 8'h10, 32'hFFFFFFFF, 32'h0);
            bus(1'b0, 8'h10, 32'h0, 32'h0);
            $display("test pass %0d done", p);
        end
        finish_test();
    end
endmodule
`default_nettype wire
